// *** design/lmd_pkg.sv ***
// constants and types shared by the legacy-mode interrupt dispatch block
// assumes a 32-bit avalon-mm register port and one synchronous clock domain
package lmd_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int         ADDR_W     = 7;
	localparam logic [6:0] OFS_MODE   = 7'h00;
	localparam logic [6:0] OFS_FCR    = 7'h04;
	localparam logic [6:0] OFS_FLAGS  = 7'h08;
	localparam logic [6:0] OFS_CPL    = 7'h0c;
	localparam logic [6:0] OFS_STATUS = 7'h10;
	localparam logic [6:0] OFS_CLEAR  = 7'h14;
	localparam logic [6:0] OFS_ENABLE = 7'h18;
	localparam logic [6:0] OFS_LAST   = 7'h1c;
	localparam logic [6:0] OFS_IOPERM = 7'h20;
	localparam logic [6:0] OFS_REDIR  = 7'h40;
	localparam logic [6:0] OFS_PAGE   = 7'h60;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int          MODE_COMPAT_BIT = 0;
	localparam int          FCR_EXT_BIT     = 0;
	localparam int          FLAGS_IO_PRIVILEGE_FIELD_LO   = 12;
	localparam int          FLAGS_VIF_BIT   = 19;
	localparam int          FLAGS_VIP_BIT   = 20;
	localparam logic [31:0] RST_WORD        = 32'h0000_0000;
	localparam logic [31:0] RST_PAGE        = 32'hffff_ffff;
	localparam logic [1:0]  RST_CPL         = 2'h0;
	localparam logic [1:0]  CPL_COMPAT      = 2'h3;
	localparam logic [1:0]  IO_PRIVILEGE_FIELD_MAX        = 2'h3;

	// ----------------------------------------------------------------
	// status bits, classes, vectors
	// ----------------------------------------------------------------
	localparam int         ST_IO_TRAP   = 0;
	localparam int         ST_PAGE_TRAP = 1;
	localparam int         ST_GP        = 2;
	localparam int         ST_CLASS1    = 3;
	localparam int         ST_CLASS2    = 4;
	localparam int         ST_CLASS3    = 5;
	localparam int         ST_W         = 6;
	localparam logic [1:0] CLASS_NONE   = 2'h0;
	localparam logic [1:0] CLASS_1      = 2'h1;
	localparam logic [1:0] CLASS_2      = 2'h2;
	localparam logic [1:0] CLASS_3      = 2'h3;
	localparam logic [7:0] GP_VEC       = 8'h0d;
	// page trap vector is a plain default, adjust per system
	localparam logic [7:0] PAGE_VEC     = 8'h0e;
	localparam logic [7:0] PORT_LIMIT   = 8'hff;

	typedef enum logic [2:0] {
		EV_EXC, EV_NMI, EV_EXT, EV_MASKABLE, EV_SOFT, EV_IO, EV_MEM, EV_SENS
	} lmd_kind_t;

	typedef enum logic [2:0] {
		PATH_PASS, PATH_PM, PATH_PROG, PATH_VIRT, PATH_GP, PATH_PAGE
	} lmd_path_t;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lmd_merge(input logic [31:0] old_w,
	                                          input logic [31:0] new_w,
	                                          input logic [3:0]  be);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return r;
	endfunction : lmd_merge

	function automatic logic [31:0] lmd_word(input logic [255:0] v, input logic [2:0] i);
		return v[i*32 +: 32];
	endfunction : lmd_word

endpackage : lmd_pkg

// *** design/lmd_dec_if.sv ***
// decision bundle between the dispatch top and its classifier
// assumes both ends sit in the sys_clk domain; contents are combinational
`timescale 1ns/1ps
interface lmd_dec_if;
	import lmd_pkg::*;
	lmd_kind_t  kind;
	logic [7:0] vector;
	logic       perm_bit;
	logic       redir_bit;
	logic       page_ok;
	logic       compat;
	logic       ext_en;
	logic [1:0] io_privilege_field;
	logic [1:0] current_privilege_level;
	logic [1:0] cls;
	lmd_path_t  path;
	logic [7:0] vec_out;

	modport dec (input kind, vector, perm_bit, redir_bit, page_ok, compat, ext_en,
	             io_privilege_field, current_privilege_level, output cls, path, vec_out);
	modport top (output kind, vector, perm_bit, redir_bit, page_ok, compat, ext_en,
	             io_privilege_field, current_privilege_level, input cls, path, vec_out);
endinterface : lmd_dec_if

// *** design/lmd_classify.sv ***
// combinational event classifier for the legacy compatibility mode
// assumes the top supplies looked-up bitmap bits and the effective privilege
`timescale 1ns/1ps
module lmd_classify
	import lmd_pkg::*;
(
	lmd_dec_if.dec d
);

	// ----------------------------------------------------------------
	// class and path decision
	// ----------------------------------------------------------------
	always_comb begin
		d.cls     = CLASS_NONE;
		d.path    = PATH_PASS;
		d.vec_out = d.vector;
		case (d.kind)
			EV_EXC, EV_NMI, EV_EXT: begin
				d.cls  = CLASS_1;
				d.path = PATH_PM;
			end
			EV_MASKABLE: begin
				if (d.compat && d.ext_en) begin
					d.cls  = CLASS_2;
					d.path = PATH_VIRT;
				end else begin
					d.cls  = CLASS_1;
					d.path = PATH_PM;
				end
			end
			EV_SOFT: begin
				d.cls = CLASS_3;
				// with extensions on, a clear redirect flag keeps it in the program
				if (d.compat && d.ext_en && !d.redir_bit) begin
					d.path = PATH_PROG;
				end else if (!d.compat || d.io_privilege_field == IO_PRIVILEGE_FIELD_MAX) begin
					d.path = PATH_PM;
				end else begin
					d.path    = PATH_GP;
					d.vec_out = GP_VEC;
				end
			end
			EV_IO: begin
				if (!d.compat && d.current_privilege_level <= d.io_privilege_field) begin
					d.path = PATH_PASS;
				end else if (d.perm_bit) begin
					d.path    = PATH_GP;
					d.vec_out = GP_VEC;
				end
			end
			EV_MEM: begin
				if (!d.page_ok) begin
					d.path    = PATH_PAGE;
					d.vec_out = PAGE_VEC;
				end
			end
			EV_SENS: begin
				if (d.compat && d.io_privilege_field < IO_PRIVILEGE_FIELD_MAX) begin
					d.path    = PATH_GP;
					d.vec_out = GP_VEC;
				end
			end
			default: begin
				d.path = PATH_PASS;
			end
		endcase
	end

endmodule : lmd_classify

// *** design/lmd_dispatch.sv ***
// legacy compatibility mode trap and interrupt dispatch, with avalon-mm registers
// assumes events are synchronous to sys_clk and one may arrive every cycle
//
// Contract
// - in compat mode, I/O ports marked in the task's bitmap trap
// - protected mode passes I/O when privilege at most I/O privilege; not compat
// - access to a not-present page traps
// - exceptions, NMI and pin interrupts are class 1, to descriptor-table handler
// - maskable interrupts with extensions on are class 2; soft interrupts class 3
// - I/O privilege field, flags bits 12-13, picks class 3 path, gates virtual flags
// - extensions on only when bit 0 of fourth control register is set
// - 256-flag redirection bitmap sends class 3 to program or protected handler
// - without extensions, maskable interrupts are handled like class 1
// - general-protection faults go out on vector 13
// - compat privilege is 3; sensitive instructions fault if field below 3
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module lmd_dispatch
	import lmd_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              evt_valid,
	input  wire lmd_kind_t         evt_kind,
	input  wire logic [7:0]        evt_vector,
	input  wire logic [15:0]       evt_port,
	input  wire logic [4:0]        evt_page,
	output logic                   disp_valid,
	output logic      [1:0]        disp_class,
	output lmd_path_t              disp_path,
	output logic      [7:0]        disp_vector,
	output logic                   virt_flags_active,
	output logic                   irq
);

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [31:0]     mode_q;
	logic [31:0]     fcr_q;
	logic [31:0]     flags_q;
	logic [1:0]      cpl_q;
	logic [ST_W-1:0] status_q;
	logic [ST_W-1:0] enable_q;
	logic [255:0]    ioperm_q;
	logic [255:0]    redir_q;
	logic [31:0]     page_q;
	logic [31:0]     last_q;
	logic            ack_q;
	logic [31:0]     rdata_d;

	logic            wr_go;
	logic            compat;
	logic            ext_en;
	logic [1:0]      io_privilege_field;
	logic [1:0]      cpl_eff;
	logic [ST_W-1:0] ev_set;
	logic [ST_W-1:0] clr_mask;

	assign compat  = mode_q[MODE_COMPAT_BIT];
	assign ext_en  = fcr_q[FCR_EXT_BIT];
	assign io_privilege_field    = flags_q[FLAGS_IO_PRIVILEGE_FIELD_LO +: 2];
	// the legacy program always runs at user privilege
	assign cpl_eff = compat ? CPL_COMPAT : cpl_q;

	// virtual flags only usable with extensions on and the privilege field below 3
	assign virt_flags_active = compat && ext_en && (io_privilege_field < IO_PRIVILEGE_FIELD_MAX);

	// ----------------------------------------------------------------
	// avalon-mm slave: one wait cycle, then the answer
	// ----------------------------------------------------------------
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign wr_go           = avs_write && ack_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read || avs_write) && !ack_q;
		end
	end

	always_comb begin
		rdata_d = RST_WORD;
		if (avs_address >= OFS_IOPERM && avs_address < OFS_REDIR) begin
			rdata_d = lmd_word(ioperm_q, avs_address[4:2]);
		end else if (avs_address >= OFS_REDIR && avs_address < OFS_PAGE) begin
			rdata_d = lmd_word(redir_q, avs_address[4:2]);
		end else begin
			case (avs_address)
				OFS_MODE:   rdata_d = mode_q;
				OFS_FCR:    rdata_d = fcr_q;
				OFS_FLAGS:  rdata_d = flags_q;
				OFS_CPL:    rdata_d = {30'h0, cpl_eff};
				OFS_STATUS: rdata_d = {{(32-ST_W){1'b0}}, status_q};
				OFS_ENABLE: rdata_d = {{(32-ST_W){1'b0}}, enable_q};
				OFS_LAST:   rdata_d = last_q;
				OFS_PAGE:   rdata_d = page_q;
				default:    rdata_d = RST_WORD;
			endcase
		end
	end

	// read data is loaded during the wait cycle so it stands at the answer edge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= RST_WORD;
		end else if (avs_read && !ack_q) begin
			avs_readdata <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mode_q  <= RST_WORD;
			fcr_q   <= RST_WORD;
			flags_q <= RST_WORD;
			cpl_q   <= RST_CPL;
		end else if (wr_go) begin
			case (avs_address)
				OFS_MODE:  mode_q  <= lmd_merge(mode_q, avs_writedata, avs_byteenable);
				OFS_FCR:   fcr_q   <= lmd_merge(fcr_q, avs_writedata, avs_byteenable);
				OFS_FLAGS: flags_q <= lmd_merge(flags_q, avs_writedata, avs_byteenable);
				OFS_CPL: begin
					if (avs_byteenable[0]) begin
						cpl_q <= avs_writedata[1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			enable_q <= {ST_W{1'b0}};
		end else if (wr_go && avs_address == OFS_ENABLE && avs_byteenable[0]) begin
			enable_q <= avs_writedata[ST_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// per-task bitmaps and page presence
	// ----------------------------------------------------------------
	// software reloads these on each task switch; ports above 255 trap unless protected-mode privilege passes the I/O
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ioperm_q <= '0;
			redir_q  <= '0;
			page_q   <= RST_PAGE;
		end else if (wr_go) begin
			if (avs_address >= OFS_IOPERM && avs_address < OFS_REDIR) begin
				ioperm_q[avs_address[4:2]*32 +: 32] <= lmd_merge(
					lmd_word(ioperm_q, avs_address[4:2]), avs_writedata, avs_byteenable);
			end else if (avs_address >= OFS_REDIR && avs_address < OFS_PAGE) begin
				redir_q[avs_address[4:2]*32 +: 32] <= lmd_merge(
					lmd_word(redir_q, avs_address[4:2]), avs_writedata, avs_byteenable);
			end else if (avs_address == OFS_PAGE) begin
				page_q <= lmd_merge(page_q, avs_writedata, avs_byteenable);
			end
		end
	end

	// ----------------------------------------------------------------
	// classification
	// ----------------------------------------------------------------
	lmd_dec_if dec_if ();

	assign dec_if.kind      = evt_kind;
	assign dec_if.vector    = evt_vector;
	assign dec_if.perm_bit  = (evt_port > {8'h00, PORT_LIMIT}) || ioperm_q[evt_port[7:0]];
	assign dec_if.redir_bit = redir_q[evt_vector];
	assign dec_if.page_ok   = page_q[evt_page];
	assign dec_if.compat    = compat;
	assign dec_if.ext_en    = ext_en;
	assign dec_if.io_privilege_field      = io_privilege_field;
	assign dec_if.current_privilege_level       = cpl_eff;

	lmd_classify u_classify (
		.d (dec_if.dec)
	);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			disp_valid  <= 1'b0;
			disp_class  <= CLASS_NONE;
			disp_path   <= PATH_PASS;
			disp_vector <= 8'h00;
		end else begin
			disp_valid <= evt_valid;
			if (evt_valid) begin
				disp_class  <= dec_if.cls;
				disp_path   <= dec_if.path;
				disp_vector <= dec_if.vec_out;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			last_q <= RST_WORD;
		end else if (evt_valid) begin
			last_q <= {16'h0, dec_if.vec_out, 3'h0, dec_if.path, dec_if.cls};
		end
	end

	// ----------------------------------------------------------------
	// sticky status and interrupt
	// ----------------------------------------------------------------
	always_comb begin
		ev_set               = {ST_W{1'b0}};
		ev_set[ST_IO_TRAP]   = evt_valid && evt_kind == EV_IO && dec_if.path == PATH_GP;
		ev_set[ST_PAGE_TRAP] = evt_valid && dec_if.path == PATH_PAGE;
		ev_set[ST_GP]        = evt_valid && dec_if.path == PATH_GP;
		ev_set[ST_CLASS1]    = evt_valid && dec_if.cls == CLASS_1;
		ev_set[ST_CLASS2]    = evt_valid && dec_if.cls == CLASS_2;
		ev_set[ST_CLASS3]    = evt_valid && dec_if.cls == CLASS_3;
	end

	assign clr_mask = (wr_go && avs_address == OFS_CLEAR && avs_byteenable[0]) ?
	                  avs_writedata[ST_W-1:0] : {ST_W{1'b0}};

	// a new event in the clearing cycle survives the clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			status_q <= {ST_W{1'b0}};
		end else begin
			status_q <= (status_q & ~clr_mask) | ev_set;
		end
	end

	assign irq = |(status_q & enable_q);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_io_compat_trap: assert property (@(posedge sys_clk) disable iff (rst)
		evt_valid && evt_kind == EV_IO && compat && ioperm_q[evt_port[7:0]]
		|=> disp_valid && disp_path == PATH_GP && disp_vector == GP_VEC)
		else $error("marked port in compat mode did not trap");

	a_io_pm_bypass: assert property (@(posedge sys_clk) disable iff (rst)
		evt_valid && evt_kind == EV_IO && !compat && cpl_q <= io_privilege_field
		|=> disp_path == PATH_PASS)
		else $error("privileged protected-mode io was trapped");

	a_page_absent: assert property (@(posedge sys_clk) disable iff (rst)
		evt_valid && evt_kind == EV_MEM && !page_q[evt_page]
		|=> disp_path == PATH_PAGE && status_q[ST_PAGE_TRAP])
		else $error("absent page access did not trap");

	a_class1_route: assert property (@(posedge sys_clk) disable iff (rst)
		evt_valid && (evt_kind == EV_NMI || evt_kind == EV_EXT || evt_kind == EV_EXC)
		|=> disp_class == CLASS_1 && disp_path == PATH_PM && disp_vector == $past(evt_vector))
		else $error("class 1 event misrouted");

	a_class2_ext: assert property (@(posedge sys_clk) disable iff (rst)
		evt_valid && evt_kind == EV_MASKABLE && compat && fcr_q[0]
		|=> disp_class == CLASS_2)
		else $error("maskable interrupt not class 2 with extensions on");

	a_maskable_plain: assert property (@(posedge sys_clk) disable iff (rst)
		evt_valid && evt_kind == EV_MASKABLE && !fcr_q[0]
		|=> disp_class == CLASS_1 && disp_path == PATH_PM)
		else $error("maskable interrupt not handled as class 1");

	a_soft_redirect: assert property (@(posedge sys_clk) disable iff (rst)
		evt_valid && evt_kind == EV_SOFT && compat && ext_en && !redir_q[evt_vector]
		|=> disp_class == CLASS_3 && disp_path == PATH_PROG)
		else $error("soft interrupt not redirected to program");

	a_sens_fault: assert property (@(posedge sys_clk) disable iff (rst)
		evt_valid && evt_kind == EV_SENS && compat && flags_q[13:12] != 2'h3
		|=> disp_path == PATH_GP && disp_vector == 8'h0d)
		else $error("sensitive instruction did not fault");

	a_vflag_gate: assert property (@(posedge sys_clk) disable iff (rst)
		virt_flags_active |-> fcr_q[0] && compat && flags_q[13:12] != 2'h3)
		else $error("virtual flags active outside extension mode");

	// the set must win over a clear landing in the same cycle
	a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
		ev_set[ST_GP] |=> status_q[ST_GP] && (irq || !enable_q[ST_GP]))
		else $error("fault event did not set status or raise irq");

	a_status_sticky: assert property (@(posedge sys_clk) disable iff (rst)
		status_q[ST_GP] && !clr_mask[ST_GP] |=> status_q[ST_GP])
		else $error("fault status dropped without a clear");

	a_disp_pulse: assert property (@(posedge sys_clk) disable iff (rst)
		evt_valid |=> disp_valid)
		else $error("taken event gave no dispatch pulse");

	a_disp_quiet: assert property (@(posedge sys_clk) disable iff (rst)
		!evt_valid |=> !disp_valid)
		else $error("dispatch pulse without an event");

	a_gp_vector: assert property (@(posedge sys_clk) disable iff (rst)
		disp_valid && disp_path == PATH_GP |-> disp_vector == 8'h0d)
		else $error("fault dispatched on a wrong vector");

	a_soft_class3: assert property (@(posedge sys_clk) disable iff (rst)
		evt_valid && evt_kind == EV_SOFT |=> disp_class == CLASS_3)
		else $error("soft interrupt not class 3");

	a_soft_protect: assert property (@(posedge sys_clk) disable iff (rst)
		evt_valid && evt_kind == EV_SOFT && flags_q[13:12] == 2'h3
		&& !(compat && ext_en && !redir_q[evt_vector])
		|=> disp_path == PATH_PM)
		else $error("soft interrupt at full field not sent to handler");

	a_soft_fault: assert property (@(posedge sys_clk) disable iff (rst)
		evt_valid && evt_kind == EV_SOFT && compat && flags_q[13:12] != 2'h3
		&& !(ext_en && !redir_q[evt_vector])
		|=> disp_path == PATH_GP)
		else $error("soft interrupt below full field did not fault");

	a_io_bitmap_pm: assert property (@(posedge sys_clk) disable iff (rst)
		evt_valid && evt_kind == EV_IO && !compat && cpl_q > io_privilege_field
		&& ioperm_q[evt_port[7:0]]
		|=> disp_path == PATH_GP)
		else $error("low-privilege protected-mode io skipped the bitmap");

	a_io_unmarked: assert property (@(posedge sys_clk) disable iff (rst)
		evt_valid && evt_kind == EV_IO && evt_port[15:8] == 8'h00
		&& !ioperm_q[evt_port[7:0]]
		|=> disp_path == PATH_PASS)
		else $error("unmarked port was trapped");

	a_page_present: assert property (@(posedge sys_clk) disable iff (rst)
		evt_valid && evt_kind == EV_MEM && page_q[evt_page]
		|=> disp_path == PATH_PASS)
		else $error("present page access was trapped");

endmodule : lmd_dispatch

// *** tb/lmd_evt_src.sv ***
// event source model: exceptions, interrupt pins, soft interrupts, I/O and page accesses
// assumes the dispatcher takes one event at each sys_clk edge that sees evt_valid high
`timescale 1ns/1ps
module lmd_evt_src
	import lmd_pkg::*;
(
	input  wire logic   sys_clk,
	output logic        evt_valid,
	output lmd_kind_t   evt_kind,
	output logic [7:0]  evt_vector,
	output logic [15:0] evt_port,
	output logic [4:0]  evt_page
);
	initial begin
		evt_valid  = 1'b0;
		evt_kind   = EV_EXC;
		evt_vector = 8'h00;
		evt_port   = 16'h0000;
		evt_page   = 5'h00;
	end

	// ----------------------------------------------------------------
	// one-cycle event strobe
	// ----------------------------------------------------------------
	// vectors sent for class 1 are taken to hit valid gate entries
	// idle qualifiers show the inverse so a stale value never passes for a fresh one
	task automatic fire(input lmd_kind_t k, input logic [7:0] v, input logic [15:0] p,
	                    input logic [4:0] g);
		@(posedge sys_clk);
		evt_valid  <= 1'b1;
		evt_kind   <= k;
		evt_vector <= v;
		evt_port   <= p;
		evt_page   <= g;
		@(posedge sys_clk);
		evt_valid  <= 1'b0;
		evt_kind   <= lmd_kind_t'(~k);
		evt_vector <= ~v;
		evt_port   <= ~p;
		evt_page   <= ~g;
	endtask : fire
endmodule : lmd_evt_src

// *** tb/test_legacy_mode_interrupt_dispatch.sv ***
// self-checking bench for the legacy-mode dispatcher: table of events, then register cases
// assumes the dispatcher answers each bus request after one wait cycle and events a cycle late
`timescale 1ns/1ps
module test_legacy_mode_interrupt_dispatch
	import lmd_pkg::*;
;
	typedef struct {
		logic       cm, ext;
		logic [1:0] io_privilege_field, current_privilege_level;
		lmd_kind_t  k;
		logic [7:0] v;
		logic [15:0] p;
		logic [4:0] g;
		logic [1:0] cls;
		lmd_path_t  path;
		logic [7:0] vo;
	} lmd_row_t;

	logic              sys_clk, rst, avs_read, avs_write, avs_waitrequest;
	logic [ADDR_W-1:0] avs_address;
	logic [31:0]       avs_writedata, avs_readdata, rd;
	logic [3:0]        avs_byteenable;
	logic              evt_valid, disp_valid, virt_flags_active, irq;
	lmd_kind_t         evt_kind;
	lmd_path_t         disp_path;
	logic [7:0]        evt_vector, disp_vector;
	logic [15:0]       evt_port;
	logic [4:0]        evt_page;
	logic [1:0]        disp_class;
	int                n_mismatch, n_compared;
	lmd_row_t          rows[18];

	lmd_dispatch DUT (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .evt_valid(evt_valid), .evt_kind(evt_kind),
		.evt_vector(evt_vector), .evt_port(evt_port), .evt_page(evt_page),
		.disp_valid(disp_valid), .disp_class(disp_class), .disp_path(disp_path),
		.disp_vector(disp_vector), .virt_flags_active(virt_flags_active), .irq(irq));

	lmd_evt_src src (.sys_clk(sys_clk), .evt_valid(evt_valid), .evt_kind(evt_kind),
		.evt_vector(evt_vector), .evt_port(evt_port), .evt_page(evt_page));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------------
	// bus and compare tasks
	// ----------------------------------------------------------------
	// request held until waitrequest is seen low at a rising edge; read data taken there
	task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_read      <= ~w;
		avs_write     <= w;
		avs_address   <= a;
		avs_writedata <= d;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t: value %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_disp(input lmd_row_t r);
		@(negedge sys_clk);
		n_compared++;
		if (disp_valid !== 1'b1 || disp_class !== r.cls || disp_path !== r.path ||
		    disp_vector !== r.vo) begin
			n_mismatch++;
			$display("Error %0t: dispatch %h %h %h, expected %h %h %h", $time,
			         disp_class, disp_path, disp_vector, r.cls, r.path, r.vo);
		end
	endtask : chk_disp

	task automatic setup(input logic cm, ext, input logic [1:0] io_privilege_field, current_privilege_level);
		bus(1'b1, OFS_MODE, {31'h0, cm});
		bus(1'b1, OFS_FCR, {31'h0, ext});
		bus(1'b1, OFS_FLAGS, {18'h0, io_privilege_field, 12'h0});
		bus(1'b1, OFS_CPL, {30'h0, current_privilege_level});
	endtask : setup

	task automatic results();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		results();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		// cm ext io_privilege_field cpl kind vec port page -> class path vector
		rows = '{
			'{1, 0, 0, 0, EV_EXC,      8'h06, 16'h0, 5'h0, CLASS_1,    PATH_PM,   8'h06},
			'{1, 1, 0, 0, EV_NMI,      8'h02, 16'h0, 5'h0, CLASS_1,    PATH_PM,   8'h02},
			'{1, 1, 0, 0, EV_EXT,      8'h20, 16'h0, 5'h0, CLASS_1,    PATH_PM,   8'h20},
			'{1, 1, 0, 0, EV_MASKABLE, 8'h30, 16'h0, 5'h0, CLASS_2,    PATH_VIRT, 8'h30},
			'{1, 0, 0, 0, EV_MASKABLE, 8'h30, 16'h0, 5'h0, CLASS_1,    PATH_PM,   8'h30},
			'{1, 1, 0, 0, EV_SOFT,     8'h22, 16'h0, 5'h0, CLASS_3,    PATH_PROG, 8'h22},
			'{1, 1, 3, 0, EV_SOFT,     8'h21, 16'h0, 5'h0, CLASS_3,    PATH_PM,   8'h21},
			'{1, 1, 2, 0, EV_SOFT,     8'h21, 16'h0, 5'h0, CLASS_3,    PATH_GP,   GP_VEC},
			'{1, 0, 3, 0, EV_SOFT,     8'h22, 16'h0, 5'h0, CLASS_3,    PATH_PM,   8'h22},
			'{1, 0, 3, 0, EV_IO,       8'h44, 16'h5, 5'h0, CLASS_NONE, PATH_GP,   GP_VEC},
			'{1, 0, 3, 0, EV_IO,       8'h44, 16'h6, 5'h0, CLASS_NONE, PATH_PASS, 8'h44},
			'{1, 0, 3, 0, EV_IO,       8'h44, 16'h100, 5'h0, CLASS_NONE, PATH_GP, GP_VEC},
			'{0, 0, 0, 0, EV_IO,       8'h44, 16'h5, 5'h0, CLASS_NONE, PATH_PASS, 8'h44},
			'{0, 0, 0, 3, EV_IO,       8'h44, 16'h5, 5'h0, CLASS_NONE, PATH_GP,   GP_VEC},
			'{1, 0, 0, 0, EV_MEM,      8'h55, 16'h0, 5'h2, CLASS_NONE, PATH_PAGE, PAGE_VEC},
			'{1, 0, 0, 0, EV_MEM,      8'h55, 16'h0, 5'h3, CLASS_NONE, PATH_PASS, 8'h55},
			'{1, 0, 2, 0, EV_SENS,     8'h66, 16'h0, 5'h0, CLASS_NONE, PATH_GP,   GP_VEC},
			'{1, 0, 3, 0, EV_SENS,     8'h66, 16'h0, 5'h0, CLASS_NONE, PATH_PASS, 8'h66}};
		n_mismatch     = 0;
		n_compared     = 0;
		rst            = 1'b1;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_address    = 7'h00;
		avs_writedata  = 32'h0;
		avs_byteenable = 4'hf;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		bus(1'b0, OFS_PAGE, 32'h0);
		chk(rd, RST_PAGE);
		bus(1'b0, OFS_MODE, 32'h0);
		chk(rd, RST_WORD);
		// port 5 marked, vector 21 sent to protected handler, page 2 absent
		bus(1'b1, OFS_IOPERM, 32'h0000_0020);
		bus(1'b1, OFS_REDIR + 7'h04, 32'h0000_0002);
		bus(1'b1, OFS_PAGE, 32'hffff_fffb);
		foreach (rows[i]) begin
			setup(rows[i].cm, rows[i].ext, rows[i].io_privilege_field, rows[i].current_privilege_level);
			src.fire(rows[i].k, rows[i].v, rows[i].p, rows[i].g);
			chk_disp(rows[i]);
		end
		// privilege reads 3 in compat mode; virtual flags follow the extension bit
		setup(1'b1, 1'b1, 2'h2, 2'h0);
		bus(1'b0, OFS_CPL, 32'h0);
		chk(rd, {30'h0, CPL_COMPAT});
		@(negedge sys_clk);
		chk({31'h0, virt_flags_active}, 32'h1);
		setup(1'b1, 1'b0, 2'h2, 2'h0);
		@(negedge sys_clk);
		chk({31'h0, virt_flags_active}, 32'h0);
		// status, enable and clear around a fault; masked first, then enabled
		bus(1'b1, OFS_CLEAR, 32'h3f);
		bus(1'b1, OFS_ENABLE, 32'h0);
		src.fire(EV_SENS, 8'h66, 16'h0, 5'h0);
		repeat (2) @(negedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h1 << ST_GP);
		bus(1'b0, OFS_LAST, 32'h0);
		chk(rd, {16'h0, GP_VEC, 3'h0, PATH_GP, CLASS_NONE});
		bus(1'b1, OFS_ENABLE, 32'h1 << ST_GP);
		@(negedge sys_clk);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, OFS_CLEAR, 32'h1 << ST_GP);
		@(negedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		// a mid-run reset drops a pending interrupt and restores the registers
		src.fire(EV_SENS, 8'h66, 16'h0, 5'h0);
		@(negedge sys_clk);
		chk({31'h0, irq}, 32'h1);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		chk({30'h0, irq, disp_valid}, 32'h0);
		bus(1'b0, OFS_PAGE, 32'h0);
		chk(rd, RST_PAGE);
		bus(1'b0, OFS_ENABLE, 32'h0);
		chk(rd, 32'h0);
		// read-only status ignores writes; unmapped space reads zero
		bus(1'b1, OFS_STATUS, 32'h3f);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 7'h7c, 32'h0);
		chk(rd, 32'h0);
		results();
	end
endmodule : test_legacy_mode_interrupt_dispatch
